// File: logic/sap_pkg.sv
// Purpose: shared constants and carriers of the serial adapter status block
// Assumes: one clock mclk at 25 MHz, all bus and modem pins asynchronous to it
// Notes:   register selects index the four bus addresses
package sap_pkg;

    // ==================================================================
    // register select codes {register_select_high, register_select_low}
    localparam logic [1:0] RS_DATA   = 2'h0;
    localparam logic [1:0] RS_STATUS = 2'h1;
    localparam logic [1:0] RS_CMD    = 2'h2;
    localparam logic [1:0] RS_CTRL   = 2'h3;

    // ==================================================================
    // line_status bit positions
    localparam int ST_IRQ  = 7;
    localparam int ST_DSR  = 6;
    localparam int ST_DCD  = 5;
    localparam int ST_TXE  = 4;
    localparam int ST_RXF  = 3;
    localparam int ST_OVR  = 2;
    localparam int ST_FE   = 1;
    localparam int ST_PE   = 0;

    // ==================================================================
    // command and control fields
    localparam int CMD_DTR      = 0;
    localparam int CMD_IRD      = 1;
    localparam int CMD_TIC_LO   = 2;
    localparam int CMD_TIC_HI   = 3;
    localparam int CTRL_WL_LO   = 5;
    localparam int CTRL_WL_HI   = 6;
    localparam logic [1:0] TIC_TX_IRQ_ON = 2'h1;
    localparam logic [7:0] CMD_PROG_RESET_KEEP = 8'he0;

    // word length codes: 8, 7, 6, 5 bits
    localparam logic [1:0] WL_8 = 2'h0;
    localparam logic [1:0] WL_7 = 2'h1;
    localparam logic [1:0] WL_6 = 2'h2;
    localparam logic [7:0] MASK_8 = 8'hff;
    localparam logic [7:0] MASK_7 = 8'h7f;
    localparam logic [7:0] MASK_6 = 8'h3f;
    localparam logic [7:0] MASK_5 = 8'h1f;

    // ==================================================================
    // reset values
    localparam logic [7:0] CMD_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [1:0] MODEM_RESET = 2'h3;
    localparam int         FIFO_DEPTH  = 8;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic       phi2;
        logic       cs0;
        logic       cs1_n;
        logic       register_select_high;
        logic       register_select_low;
        logic       rw;
        logic [7:0] data;
        logic       dsr_n;
        logic       dcd_n;
    } sap_pins_s;

    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
        logic       framing_err;
    } sap_rx_word_s;

    localparam int RX_WORD_W = $bits(sap_rx_word_s);

endpackage

// File: logic/sap_top.sv
// Purpose: bus side status, interrupt and holding registers of a serial adapter
// Assumes: bus pins and modem inputs are asynchronous to mclk; the shifters run on mclk
// Notes:   a bus transfer commits on the falling edge of the synchronised phase-2 clock
//
// What this block does
// - interrupt request pin pulled low while an enabled condition awaits the processor
// - enabled condition sets status bit 7 along with its own bit 3..6
// - status bits 6,5,4,3 report DSR, DCD, transmit empty, receive full
// - status bits 2,1,0 report overrun, framing error, parity error
// - summary bit 7 set whenever an enabled interrupt condition in bits 6..3 fires
// - summary bit goes 1 on any enabled condition, 0 on a status read
// - bus data exchanged only while selected and phase-2 clock high
// - selected: low read/write writes the device, high drives the bus
// - both selects low: write goes to transmit, read returns receive holding
// - transmitted holding bits above word length are ignored; bit 0 goes first
// - receive holding: first bit in bit 0, zeros above word length
// - received parity bit is only checked, never stored
// - parity, framing and overrun flags never raise an interrupt
// - parity, framing and overrun flags clear after a receive holding read
// - receive full sets on character load, clears on holding read
// - transmit empty sets on move to shifter, clears on holding write
// - DSR and DCD bits show pin level: 0 low, 1 high
// - DSR or DCD change raises interrupt unless receiver interrupt disable is 1
// - modem bits freeze after a change until status read, then update again
// - nothing internal clears the DSR and DCD bits
// - receive full and transmit empty interrupt only when command enables allow
// - hardware reset initialises every register
// - hardware reset clears status except modem bits, sets transmit empty
// - programmed reset clears command bits 4..0 and overrun, keeps control
// - receiver interrupt needs disable bit 0 and terminal-ready bit 1

// ======================================================================
// fifo between receive shifter and receive holding register
module sap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // write side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // read side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sap_fifo: depth must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
    } sap_fifo_state_s;

    sap_fifo_state_s s_q;
    sap_fifo_state_s s_d;
    logic            push;
    logic            pop;

    assign in_ready  = (s_q.count != DEPTH[AW:0]);
    assign out_valid = (s_q.count != '0);
    assign out_data  = s_q.mem[s_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ======================================================================
// adapter bus side, status and interrupt logic
module sap_top #(
    parameter int RX_FIFO_DEPTH = sap_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // processor bus pins
    input  wire logic                 phi2,
    input  wire logic                 cs0,
    input  wire logic                 cs1_n,
    input  wire logic                 register_select_high,
    input  wire logic                 register_select_low,
    input  wire logic                 rw,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic                      data_oe,
    // open-drain interrupt request pin
    output logic                      irq_out,
    output logic                      irq_oe,
    // modem inputs, active low
    input  wire logic                 dsr_n,
    input  wire logic                 dcd_n,
    // transmit shifter
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    output logic      [7:0]           tx_data,
    // receive shifter
    input  wire logic                 rx_valid,
    output logic                      rx_ready,
    input  wire sap_pkg::sap_rx_word_s rx_word,
    // configuration to the shifters
    output logic      [7:0]           command_reg,
    output logic      [7:0]           control_reg
);

    // ==================================================================
    // state
    typedef struct packed {
        sap_pkg::sap_pins_s meta;
        sap_pkg::sap_pins_s sync;
        logic               phi2_last;
        logic               acc_sel;
        logic               acc_rw;
        logic [1:0]         acc_rs;
        logic [7:0]         acc_wdata;
        logic [7:0]         dout;
        logic               doe;
        logic [7:0]         cmd;
        logic [7:0]         ctrl;
        logic [7:0]         txh;
        logic               tx_full;
        logic [7:0]         rxh;
        logic               rx_full;
        logic               ovr;
        logic               fe;
        logic               pe;
        logic               irq;
        logic [1:0]         modem;
        logic               frozen;
        logic [1:0]         init;
    } sap_state_s;

    sap_state_s           s_q;
    sap_state_s           s_d;
    sap_pkg::sap_pins_s   pins;
    sap_pkg::sap_rx_word_s fifo_word;
    logic                 fifo_valid;
    logic                 fifo_pop;
    logic                 fifo_in_ready;

    initial begin
        if (RX_FIFO_DEPTH < 2) begin
            $error("sap_top: receive fifo depth must be at least 2");
        end
    end

    // ==================================================================
    // helpers
    function automatic logic [7:0] wl_mask(input logic [7:0] ctrl);
        unique case (ctrl[sap_pkg::CTRL_WL_HI:sap_pkg::CTRL_WL_LO])
            sap_pkg::WL_8: wl_mask = sap_pkg::MASK_8;
            sap_pkg::WL_7: wl_mask = sap_pkg::MASK_7;
            sap_pkg::WL_6: wl_mask = sap_pkg::MASK_6;
            default:       wl_mask = sap_pkg::MASK_5;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input sap_state_s s);
        logic [7:0] v;
        v                   = '0;
        v[sap_pkg::ST_IRQ]  = s.irq;
        v[sap_pkg::ST_DSR]  = s.modem[1];
        v[sap_pkg::ST_DCD]  = s.modem[0];
        v[sap_pkg::ST_TXE]  = !s.tx_full;
        v[sap_pkg::ST_RXF]  = s.rx_full;
        v[sap_pkg::ST_OVR]  = s.ovr;
        v[sap_pkg::ST_FE]   = s.fe;
        v[sap_pkg::ST_PE]   = s.pe;
        status_byte         = v;
    endfunction

    // ==================================================================
    // receive fifo
    sap_fifo #(
        .WIDTH (sap_pkg::RX_WORD_W),
        .DEPTH (RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (rx_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );

    assign fifo_pop = !s_q.rx_full;

    // ==================================================================
    // next state
    always_comb begin
        logic       selected;
        logic       fall;
        logic       rd_rx;
        logic       rd_st;
        logic       rx_ev;
        logic       tx_ev;
        logic       modem_ev;
        logic       rx_irq_en;
        logic       tx_irq_en;
        logic [1:0] modem_in;
        selected  = 1'b0;
        fall      = 1'b0;
        rd_rx     = 1'b0;
        rd_st     = 1'b0;
        rx_ev     = 1'b0;
        tx_ev     = 1'b0;
        modem_ev  = 1'b0;
        rx_irq_en = 1'b0;
        tx_irq_en = 1'b0;
        modem_in  = '0;
        s_d       = s_q;

        pins      = '{phi2: phi2, cs0: cs0, cs1_n: cs1_n,
                      register_select_high: register_select_high,
                      register_select_low: register_select_low,
                      rw: rw, data: data_in, dsr_n: dsr_n, dcd_n: dcd_n};
        s_d.meta  = pins;
        s_d.sync  = s_q.meta;
        s_d.phi2_last = s_q.sync.phi2;
        selected  = s_q.sync.cs0 && !s_q.sync.cs1_n;
        fall      = s_q.phi2_last && !s_q.sync.phi2;

        s_d.doe = 1'b0;
        if (s_q.sync.phi2 && selected) begin
            s_d.acc_sel   = 1'b1;
            s_d.acc_rw    = s_q.sync.rw;
            s_d.acc_rs    = {s_q.sync.register_select_high, s_q.sync.register_select_low};
            s_d.acc_wdata = s_q.sync.data;
            s_d.doe       = s_q.sync.rw;
            unique case ({s_q.sync.register_select_high, s_q.sync.register_select_low})
                sap_pkg::RS_DATA:   s_d.dout = s_q.rxh;
                sap_pkg::RS_STATUS: s_d.dout = status_byte(s_q);
                sap_pkg::RS_CMD:    s_d.dout = s_q.cmd;
                sap_pkg::RS_CTRL:   s_d.dout = s_q.ctrl;
            endcase
        end

        // transfer commits at end of phase-2 high
        if (fall && s_q.acc_sel) begin
            s_d.acc_sel = 1'b0;
            if (s_q.acc_rw) begin
                rd_rx = (s_q.acc_rs == sap_pkg::RS_DATA);
                rd_st = (s_q.acc_rs == sap_pkg::RS_STATUS);
            end else begin
                unique case (s_q.acc_rs)
                    sap_pkg::RS_DATA: begin
                        s_d.txh     = s_q.acc_wdata;
                        s_d.tx_full = 1'b1;
                    end
                    sap_pkg::RS_STATUS: begin
                        s_d.cmd = s_q.cmd & sap_pkg::CMD_PROG_RESET_KEEP;
                        s_d.ovr = 1'b0;
                    end
                    sap_pkg::RS_CMD:  s_d.cmd  = s_q.acc_wdata;
                    sap_pkg::RS_CTRL: s_d.ctrl = s_q.acc_wdata;
                endcase
            end
        end

        if (rd_rx) begin
            s_d.pe = 1'b0;
            s_d.fe = 1'b0;
            s_d.ovr = 1'b0;
            s_d.rx_full = 1'b0;
        end
        if (rd_st) begin
            s_d.irq    = 1'b0;
            s_d.frozen = 1'b0;
        end

        if (s_q.tx_full && tx_ready && !(fall && s_q.acc_sel && !s_q.acc_rw
                                        && s_q.acc_rs == sap_pkg::RS_DATA)) begin
            s_d.tx_full = 1'b0;
            tx_ev       = 1'b1;
        end

        if (fifo_valid && !s_q.rx_full) begin
            s_d.rxh     = fifo_word.data & wl_mask(s_q.ctrl);
            s_d.pe      = fifo_word.parity_err;
            s_d.fe      = fifo_word.framing_err;
            s_d.rx_full = 1'b1;
            rx_ev       = 1'b1;
        end
        if (rx_valid && !fifo_in_ready && s_q.rx_full) begin
            s_d.ovr = 1'b1;
        end

        modem_in = {s_q.sync.dsr_n, s_q.sync.dcd_n};
        if (s_q.init != 2'h3) begin
            s_d.init  = s_q.init + 2'h1;
            s_d.modem = modem_in;
        end else if (!s_d.frozen && modem_in != s_q.modem) begin
            s_d.modem  = modem_in;
            s_d.frozen = 1'b1;
            modem_ev   = 1'b1;
        end

        rx_irq_en = !s_q.cmd[sap_pkg::CMD_IRD] && s_q.cmd[sap_pkg::CMD_DTR];
        tx_irq_en = s_q.cmd[sap_pkg::CMD_DTR] &&
                    s_q.cmd[sap_pkg::CMD_TIC_HI:sap_pkg::CMD_TIC_LO] == sap_pkg::TIC_TX_IRQ_ON;
        if ((rx_ev && rx_irq_en) || (tx_ev && tx_irq_en) ||
            (modem_ev && !s_q.cmd[sap_pkg::CMD_IRD])) begin
            s_d.irq = 1'b1;
        end
    end

    // ==================================================================
    // registers
    // hardware reset values
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q       <= '0;
            s_q.meta  <= '1;
            s_q.sync  <= '1;
            s_q.cmd   <= sap_pkg::CMD_RESET;
            s_q.ctrl  <= sap_pkg::CTRL_RESET;
            s_q.txh   <= sap_pkg::DATA_RESET;
            s_q.rxh   <= sap_pkg::DATA_RESET;
            s_q.modem <= sap_pkg::MODEM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==================================================================
    // outputs
    // irq pin pulled low while flag set
    assign irq_oe      = s_q.irq;
    assign irq_out     = 1'b0;
    assign data_out    = s_q.dout;
    assign data_oe     = s_q.doe;
    assign tx_data     = s_q.txh & wl_mask(s_q.ctrl);
    assign tx_valid    = s_q.tx_full;
    assign rx_ready    = fifo_in_ready;
    assign command_reg = s_q.cmd;
    assign control_reg = s_q.ctrl;

endmodule

// File: tb/sap_checker.sv
// Purpose: port assertions of the adapter bus side
// Assumes: pins held stable across a bus cycle as the bench does
// Notes:   pin paths pass a two flop sync, hence the past depths
module sap_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // bus pins
    input wire logic       phi2,
    input wire logic       cs0,
    input wire logic       cs1_n,
    input wire logic       register_select_high,
    input wire logic       register_select_low,
    input wire logic       rw,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       irq_out,
    input wire logic       irq_oe,
    // shifter side
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    // configuration
    input wire logic [7:0] command_reg,
    input wire logic [7:0] control_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        case (wl)
            sap_pkg::WL_8: return sap_pkg::MASK_8;
            sap_pkg::WL_7: return sap_pkg::MASK_7;
            sap_pkg::WL_6: return sap_pkg::MASK_6;
            default: return sap_pkg::MASK_5;
        endcase
    endfunction

    // ==================================================================
    // assertions
    irq_pin_a: assert property (irq_oe |-> irq_out == 1'b0)
        else $error("irq pin not pulled low");
    bus_drive_a: assert property (data_oe |-> $past(rw, 3) && $past(cs0, 3)
        && !$past(cs1_n, 3) && $past(phi2, 3))
        else $error("bus driven outside a selected read");
    tx_mask_a: assert property ((tx_data & ~wl_mask(control_reg[6:5])) == 8'h00)
        else $error("transmit bits above word length");
    rx_mask_a: assert property (data_oe && $past(!register_select_high, 3)
        && $past(!register_select_low, 3) |-> (data_out & ~wl_mask(control_reg[6:5])) == 8'h00)
        else $error("receive bits above word length");
    irq_enable_a: assert property ($rose(irq_oe) |-> $past(!command_reg[1]
        || (command_reg[3:2] == 2'b01 && command_reg[0])))
        else $error("interrupt raised without enable");
    irq_clear_a: assert property ($fell(irq_oe) |-> $past(rw && register_select_low
        && !register_select_high, 5))
        else $error("interrupt cleared without status read");
    tx_take_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("transmit word dropped without handshake");
    ctrl_write_a: assert property (!$stable(control_reg) |-> $past(!rw
        && register_select_high && register_select_low, 5))
        else $error("control changed without control write");
    rx_full_a: assert property ($fell(rx_ready) |-> $past(rx_valid))
        else $error("receive buffer filled without input");

    // ==================================================================
    // covers
    cover property ($rose(irq_oe));
    cover property ($fell(rx_ready));
    cover property (tx_valid && tx_ready);
endmodule

// File: tb/sap_shifter_model.sv
// Purpose: transmit shifter stand-in that takes holding words
// Assumes: stall from the bench holds it busy
// Notes:   records the last taken word and a count
module sap_shifter_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // transmit holding side
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // bench control and observation
    input  wire logic       stall,
    output logic      [7:0] last_word,
    output int              n_words
);
    timeunit 1ns;
    timeprecision 1ps;
    assign tx_ready = !stall;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_word <= 8'h00;
            n_words   <= 0;
        end else if (tx_valid && tx_ready) begin
            last_word <= tx_data;
            n_words   <= n_words + 1;
        end
    end
endmodule

// File: tb/sap_tb_top.sv
// Purpose: self-checking bench of the adapter bus side
// Assumes: bus cycles paced well beyond the sync delay
// Notes:   status expectations built from the bit layout
module sap_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // signals
    logic                  mclk = 1'b0, rstn = 1'b0, phi2 = 1'b0;
    logic                  cs0 = 1'b0, cs1_n = 1'b1, rw = 1'b1;
    logic                  dsr_n = 1'b1, dcd_n = 1'b1, stall = 1'b1;
    logic                  rx_valid = 1'b0;
    logic [1:0]            rs = 2'h0;
    logic [7:0]            din = 8'h00;
    sap_pkg::sap_rx_word_s rx_word = '0;
    logic [7:0]            dout, tx_data, cmd, ctrl, got, rd;
    logic                  doe, irq_out, irq_oe, tx_valid, tx_ready, rx_ready;
    int                    n_fail = 0, tests_run = 0, cycles = 0;

    always #20 mclk = ~mclk;

    sap_top sap_top_i (
        .mclk(mclk), .rstn(rstn), .phi2(phi2), .cs0(cs0), .cs1_n(cs1_n),
        .register_select_high(rs[1]), .register_select_low(rs[0]), .rw(rw),
        .data_in(din), .data_out(dout), .data_oe(doe), .irq_out(irq_out),
        .irq_oe(irq_oe), .dsr_n(dsr_n), .dcd_n(dcd_n), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .command_reg(cmd), .control_reg(ctrl)
    );

    sap_shifter_model sap_shifter_model_i (
        .mclk(mclk), .rstn(rstn), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .stall(stall), .last_word(got), .n_words()
    );

    // ==================================================================
    // tasks
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [1:0] a, input logic r, input logic [7:0] w);
        @(posedge mclk);
        #1 cs0 = 1'b1;
        cs1_n = 1'b0;
        rs = a;
        rw = r;
        din = w;
        repeat (2) @(posedge mclk);
        #1 phi2 = 1'b1;
        repeat (5) @(posedge mclk);
        #1 rd = dout;
        phi2 = 1'b0;
        chk({7'h00, doe}, {7'h00, r});
        repeat (4) @(posedge mclk);
        #1 cs0 = 1'b0;
        cs1_n = 1'b1;
        rw = 1'b1;
        chk({7'h00, doe}, 8'h00);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] w);
        bus(a, 1'b0, w);
    endtask

    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
        bus(a, 1'b1, 8'h00);
        chk(rd, exp);
    endtask

    task automatic push(input logic [7:0] d, input logic pe);
        @(posedge mclk);
        #1 rx_valid = 1'b1;
        rx_word = '{data: d, parity_err: pe, framing_err: 1'b0};
        do @(negedge mclk); while (rx_ready !== 1'b1);
        @(posedge mclk);
        #1 rx_valid = 1'b0;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            test_done();
        end
    end

    // ==================================================================
    // tests
    initial begin
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge mclk);
        rdchk(2'h1, 8'h70);
        rdchk(2'h2, 8'h00);
        rdchk(2'h3, 8'h00);
        $display("test reset done");
        wr(2'h3, 8'h20);
        wr(2'h2, 8'h05);
        wr(2'h0, 8'hff);
        chk(tx_data, 8'h7f);
        rdchk(2'h1, 8'h60);
        stall = 1'b0;
        repeat (3) @(posedge mclk);
        chk(got, 8'h7f);
        rdchk(2'h1, 8'hf0);
        rdchk(2'h1, 8'h70);
        $display("test transmit done");
        wr(2'h2, 8'h01);
        push(8'hab, 1'b1);
        repeat (3) @(posedge mclk);
        rdchk(2'h1, 8'hf9);
        rdchk(2'h0, 8'h2b);
        rdchk(2'h1, 8'h70);
        $display("test receive done");
        wr(2'h2, 8'h02);
        for (int i = 0; i < 9; i++) begin
            push(8'h10 + i[7:0], 1'b0);
        end
        chk({7'h00, rx_ready}, 8'h00);
        @(posedge mclk);
        #1 rx_valid = 1'b1;
        @(posedge mclk);
        #1 rx_valid = 1'b0;
        rdchk(2'h1, 8'h7c);
        chk({7'h00, irq_oe}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rdchk(2'h0, 8'h10 + i[7:0]);
        end
        rdchk(2'h1, 8'h70);
        $display("test overrun done");
        wr(2'h2, 8'h00);
        dsr_n = 1'b0;
        repeat (6) @(posedge mclk);
        #1 dcd_n = 1'b0;
        rdchk(2'h1, 8'hb0);
        rdchk(2'h1, 8'h90);
        rdchk(2'h1, 8'h10);
        $display("test modem done");
        wr(2'h2, 8'hff);
        wr(2'h1, 8'h00);
        rdchk(2'h2, 8'he0);
        rdchk(2'h3, 8'h20);
        @(posedge mclk);
        #1 rstn = 1'b0;
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge mclk);
        rdchk(2'h1, 8'h10);
        rdchk(2'h3, 8'h00);
        $display("test resets done");
        test_done();
    end
endmodule

bind sap_top sap_checker sap_checker_i (
    .mclk(mclk), .rstn(rstn), .phi2(phi2), .cs0(cs0), .cs1_n(cs1_n),
    .register_select_high(register_select_high), .register_select_low(register_select_low),
    .rw(rw), .data_out(data_out), .data_oe(data_oe), .irq_out(irq_out), .irq_oe(irq_oe),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .command_reg(command_reg), .control_reg(control_reg)
);
